// ---- verilog/sdt_pkg.sv ----
// Purpose: shared constants, types and tables of the serial DMA transfer control
// Assumes: one core_clk cycle is one instruction cycle
// Notes: delay and watermark tables decode the 4-bit fields of the control registers
package sdt_pkg;

    localparam int COUNT_W = 10;
    localparam int ADDR_W = 12;
    localparam int BYTE_W = 8;
    localparam int GAP_W = 12;

    localparam logic [1:0] DIR_FULL = 2'h2;
    localparam logic [1:0] DIR_TX = 2'h1;
    localparam logic [1:0] DIR_RX = 2'h0;

    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_ONE = 2'h2;
    localparam logic [1:0] SEL_TWO = 2'h1;
    localparam logic [1:0] SEL_FOUR = 2'h3;

    localparam logic [1:0] RATE_DIV4 = 2'h0;
    localparam logic [1:0] RATE_DIV16 = 2'h1;
    localparam logic [1:0] RATE_DIV64 = 2'h2;

    // instruction cycle against core clock period
    localparam int TCY_NS = 20;
    localparam int CLK_NS = 20;
    localparam int TCY_CLKS = TCY_NS / CLK_NS;

    // least inter-byte gaps with the reduced-overhead master setting
    localparam int GAP_DIV4_TCY = 8;
    localparam int GAP_DIV16_TCY = 9;
    localparam int GAP_DIV64_TCY = 15;
    // hardware overhead between bytes when extra delay is added
    localparam int MASTER_BASE_TCY = 8;
    localparam logic [GAP_W-1:0] MASTER_BASE_CLKS = GAP_W'(MASTER_BASE_TCY * TCY_CLKS);

    localparam logic [BYTE_W-1:0] TX_FILL = 8'hFF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 10'h000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_READ, ST_LOAD, ST_SHIFT, ST_STORE, ST_NEXT, ST_GAP
    } sdt_state_t;

    function automatic logic [GAP_W-1:0] sdt_delay_tcy(input logic [3:0] code);
        case (code)
            4'h9: sdt_delay_tcy = 12'h180;
            4'hA: sdt_delay_tcy = 12'h200;
            4'hB: sdt_delay_tcy = 12'h280;
            4'hC: sdt_delay_tcy = 12'h300;
            4'hD: sdt_delay_tcy = 12'h380;
            4'hE: sdt_delay_tcy = 12'h400;
            4'hF: sdt_delay_tcy = 12'h800;
            default: sdt_delay_tcy = 12'h001 << code;
        endcase
    endfunction : sdt_delay_tcy

    function automatic logic [COUNT_W-1:0] sdt_watermark(input logic [3:0] code);
        case (code)
            4'h0: sdt_watermark = 10'h000;
            4'h7: sdt_watermark = 10'h043;
            4'h8: sdt_watermark = 10'h080;
            4'h9: sdt_watermark = 10'h0C0;
            4'hA: sdt_watermark = 10'h100;
            4'hB: sdt_watermark = 10'h140;
            4'hC: sdt_watermark = 10'h180;
            4'hD: sdt_watermark = 10'h1C0;
            4'hE: sdt_watermark = 10'h200;
            4'hF: sdt_watermark = 10'h240;
            default: sdt_watermark = 10'h001 << (code - 4'h1);
        endcase
    endfunction : sdt_watermark

    function automatic logic [GAP_W-1:0] sdt_min_gap(input logic [1:0] rate);
        case (rate)
            RATE_DIV4: sdt_min_gap = GAP_W'(GAP_DIV4_TCY * TCY_CLKS);
            RATE_DIV16: sdt_min_gap = GAP_W'(GAP_DIV16_TCY * TCY_CLKS);
            default: sdt_min_gap = GAP_W'(GAP_DIV64_TCY * TCY_CLKS);
        endcase
    endfunction : sdt_min_gap

endpackage : sdt_pkg

// ---- verilog/sdt_sync.sv ----
// Purpose: three-stage synchroniser, output follows once stages two and three agree
// Assumes: input bits change slowly against the receiving clock
// Notes: stage one feeds stage two only
`timescale 1ns/1ps
module sdt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                sync_out <= stage3;
            end
        end
    end
endmodule : sdt_sync

// ---- verilog/sdt_link.sv ----
// Purpose: link-side byte shifter on the serial clock
// Assumes: tx_byte is held stable from go toggle until the done toggle returns
// Notes: msb first; in slave role shifts only while the select pin is low
`timescale 1ns/1ps
module sdt_link
    import sdt_pkg::*;
(
    input wire logic link_clk,
    input wire logic resetn,
    input wire logic go_toggle,
    input wire logic master_mode,
    input wire logic [sdt_pkg::BYTE_W-1:0] tx_byte,
    input wire logic port_two_select_n,
    input wire logic serial_in_two,
    output logic serial_out_two,
    output logic [sdt_pkg::BYTE_W-1:0] rx_byte,
    output logic done_toggle
);
    logic go_s;
    logic mst_s;
    logic go_seen;
    logic armed;
    logic [2:0] bit_cnt;
    logic [BYTE_W-1:0] shift;

    sdt_sync #(.WIDTH(2)) u_go_sync (
        .clk(link_clk),
        .resetn(resetn),
        .async_in({master_mode, go_toggle}),
        .sync_out({mst_s, go_s})
    );

    wire go_new = go_s != go_seen;
    wire shift_en = armed && (mst_s || !port_two_select_n);
    wire [BYTE_W-1:0] next_shift = {shift[BYTE_W-2:0], serial_in_two};

    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            go_seen <= 1'b0;
            armed <= 1'b0;
            bit_cnt <= '0;
            shift <= '0;
            serial_out_two <= 1'b0;
            rx_byte <= '0;
            done_toggle <= 1'b0;
        end else begin
            go_seen <= go_s;
            if (go_new) begin
                shift <= tx_byte;
                armed <= 1'b1;
                bit_cnt <= '0;
                serial_out_two <= tx_byte[BYTE_W-1];
            end else if (shift_en) begin
                shift <= next_shift;
                serial_out_two <= shift[BYTE_W-2];
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == BIT_LAST) begin
                    armed <= 1'b0;
                    rx_byte <= next_shift;
                    done_toggle <= ~done_toggle;
                end
            end
        end
    end
endmodule : sdt_link

// ---- verilog/sdt_core.sv ----
// Purpose: DMA control between SRAM and the second serial port, master or slave
// Assumes: SRAM returns read data one cycle after it samples sram_rd
// Notes: link logic runs on link_clk; bytes cross by toggle handshakes
`timescale 1ns/1ps
module sdt_core
    import sdt_pkg::*;
#(
    parameter logic [sdt_pkg::BYTE_W-1:0] TX_FILL_BYTE = sdt_pkg::TX_FILL
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic sleep_mode,
    input wire logic deep_sleep,
    input wire logic transfer_start,
    input wire logic transfer_stop,
    input wire logic flag_clear,
    input wire logic master_mode,
    input wire logic [1:0] direction_select,
    input wire logic tx_pointer_step,
    input wire logic rx_pointer_step,
    input wire logic [1:0] select_pulse_control,
    input wire logic delay_interrupt_select,
    input wire logic [3:0] delay_cycle_field,
    input wire logic [3:0] watermark_level,
    input wire logic [1:0] clock_rate_select,
    input wire logic [sdt_pkg::COUNT_W-1:0] byte_count_load,
    input wire logic [sdt_pkg::ADDR_W-1:0] tx_addr_load,
    input wire logic [sdt_pkg::ADDR_W-1:0] rx_addr_load,
    input wire logic [sdt_pkg::BYTE_W-1:0] sram_rdata,
    input wire logic serial_in_two,
    input wire logic port_two_select_n,
    output logic transfer_active_bit,
    output logic serial_port_two_flag,
    output logic [sdt_pkg::ADDR_W-1:0] transmit_source_pointer,
    output logic [sdt_pkg::ADDR_W-1:0] receive_dest_pointer,
    output logic [sdt_pkg::COUNT_W-1:0] transfer_byte_count,
    output logic [sdt_pkg::ADDR_W-1:0] sram_addr,
    output logic sram_rd,
    output logic sram_wr,
    output logic [sdt_pkg::BYTE_W-1:0] sram_wdata,
    output logic serial_out_two,
    output logic dma_select_n,
    output logic dma_select_oe_n,
    output logic master_clk_run
);
    import sdt_pkg::*;

    sdt_state_t state;
    logic go_toggle;
    logic [BYTE_W-1:0] tx_hold;
    logic [BYTE_W-1:0] rx_byte;
    logic done_toggle;
    logic done_s;
    logic done_seen;
    logic stop_req;
    logic [GAP_W-1:0] gap_cnt;
    logic [GAP_W-1:0] idle_cnt;
    logic seen_byte;
    logic timeout_fired;
    logic [1:0] group_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // link side and return crossing

    sdt_link u_link (
        .link_clk(link_clk),
        .resetn(resetn),
        .go_toggle(go_toggle),
        .master_mode(master_mode),
        .tx_byte(tx_hold),
        .port_two_select_n(port_two_select_n),
        .serial_in_two(serial_in_two),
        .serial_out_two(serial_out_two),
        .rx_byte(rx_byte),
        .done_toggle(done_toggle)
    );

    sdt_sync #(.WIDTH(1)) u_done_sync (
        .clk(core_clk),
        .resetn(resetn),
        .async_in(done_toggle),
        .sync_out(done_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    wire byte_done = done_s != done_seen;
    wire dir_tx = (direction_select == DIR_TX) || (direction_select == DIR_FULL);
    wire dir_rx = (direction_select == DIR_RX) || (direction_select == DIR_FULL);
    wire sel_on = master_mode && (select_pulse_control != SEL_NONE)
                  && !delay_interrupt_select;
    wire [1:0] group_last = (select_pulse_control == SEL_FOUR) ? 2'h3 :
                            (select_pulse_control == SEL_TWO) ? 2'h1 : 2'h0;
    wire last_byte = transfer_byte_count == COUNT_ZERO;
    wire shift_done = (state == ST_SHIFT) && byte_done;
    wire good_done = shift_done && !stop_req;
    wire [GAP_W-1:0] extra_gap = GAP_W'(sdt_delay_tcy(delay_cycle_field) * TCY_CLKS);
    wire [GAP_W-1:0] gap_need = delay_interrupt_select ? sdt_min_gap(clock_rate_select)
                                : GAP_W'(MASTER_BASE_CLKS + extra_gap);
    wire can_launch = transfer_active_bit && !sleep_mode;
    wire wm_hit = good_done
                  && (transfer_byte_count == sdt_watermark(watermark_level));
    wire timeout_hit = transfer_active_bit && delay_interrupt_select && seen_byte
                       && !timeout_fired && (idle_cnt == extra_gap);
    wire plain_done = byte_done && !transfer_active_bit;
    wire flag_set = wm_hit || timeout_hit || plain_done;
    wire abort_now = transfer_stop && (state != ST_SHIFT);
    wire next_done_seen = done_s;

    ////////////////////////////////////////////////////////////////////////////
    // byte sequencer

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            transfer_active_bit <= 1'b0;
            stop_req <= 1'b0;
            go_toggle <= 1'b0;
            tx_hold <= '0;
            sram_rd <= 1'b0;
            sram_wr <= 1'b0;
            sram_addr <= '0;
            sram_wdata <= '0;
            transmit_source_pointer <= '0;
            receive_dest_pointer <= '0;
            transfer_byte_count <= '0;
            gap_cnt <= '0;
            master_clk_run <= 1'b0;
        end else if (deep_sleep) begin
            state <= ST_IDLE;
            transfer_active_bit <= 1'b0;
            stop_req <= 1'b0;
            sram_rd <= 1'b0;
            sram_wr <= 1'b0;
            master_clk_run <= 1'b0;
        end else if (abort_now && transfer_active_bit) begin
            state <= ST_IDLE;
            transfer_active_bit <= 1'b0;
            sram_rd <= 1'b0;
            sram_wr <= 1'b0;
            master_clk_run <= 1'b0;
        end else begin
            sram_rd <= 1'b0;
            sram_wr <= 1'b0;
            if (transfer_stop) begin
                stop_req <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    stop_req <= 1'b0;
                    if (transfer_start && !transfer_active_bit) begin
                        transfer_active_bit <= 1'b1;
                        transmit_source_pointer <= tx_addr_load;
                        receive_dest_pointer <= rx_addr_load;
                        transfer_byte_count <= byte_count_load;
                    end else if (can_launch && dir_tx) begin
                        state <= ST_FETCH;
                    end else if (can_launch) begin
                        tx_hold <= TX_FILL_BYTE;
                        go_toggle <= ~go_toggle;
                        state <= ST_SHIFT;
                    end
                end
                ST_FETCH: begin
                    sram_addr <= transmit_source_pointer;
                    sram_rd <= 1'b1;
                    state <= ST_READ;
                end
                ST_READ: begin
                    state <= ST_LOAD;
                end
                ST_LOAD: begin
                    tx_hold <= sram_rdata;
                    go_toggle <= ~go_toggle;
                    state <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    master_clk_run <= master_mode && !byte_done;
                    if (shift_done && stop_req) begin
                        state <= ST_IDLE;
                        transfer_active_bit <= 1'b0;
                    end else if (byte_done) begin
                        if (dir_tx && tx_pointer_step) begin
                            transmit_source_pointer <= transmit_source_pointer + 12'h001;
                        end
                        state <= dir_rx ? ST_STORE : ST_NEXT;
                    end
                end
                ST_STORE: begin
                    sram_addr <= receive_dest_pointer;
                    sram_wdata <= rx_byte;
                    sram_wr <= 1'b1;
                    if (rx_pointer_step) begin
                        receive_dest_pointer <= receive_dest_pointer + 12'h001;
                    end
                    state <= ST_NEXT;
                end
                ST_NEXT: begin
                    gap_cnt <= '0;
                    if (last_byte) begin
                        transfer_active_bit <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        transfer_byte_count <= transfer_byte_count - 10'h001;
                        state <= master_mode ? ST_GAP : ST_IDLE;
                    end
                end
                ST_GAP: begin
                    if (!sleep_mode) begin
                        gap_cnt <= gap_cnt + 12'h001;
                    end
                    if (gap_cnt >= gap_need) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte-done edge, idle timer and flag

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            done_seen <= 1'b0;
            idle_cnt <= '0;
            seen_byte <= 1'b0;
            timeout_fired <= 1'b0;
        end else begin
            done_seen <= next_done_seen;
            if (byte_done || !transfer_active_bit) begin
                idle_cnt <= '0;
                timeout_fired <= 1'b0;
                seen_byte <= byte_done && transfer_active_bit;
            end else begin
                if (seen_byte && !sleep_mode && (idle_cnt != extra_gap)) begin
                    idle_cnt <= idle_cnt + 12'h001;
                end
                if (timeout_hit) begin
                    timeout_fired <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            serial_port_two_flag <= 1'b0;
        end else if (flag_set) begin
            serial_port_two_flag <= 1'b1;
        end else if (flag_clear) begin
            serial_port_two_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // automatic slave select

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dma_select_n <= 1'b1;
            dma_select_oe_n <= 1'b1;
            group_cnt <= '0;
        end else begin
            dma_select_oe_n <= !sel_on;
            if (!sel_on || !transfer_active_bit || deep_sleep) begin
                dma_select_n <= 1'b1;
                group_cnt <= '0;
            end else if ((state == ST_SHIFT) && !byte_done) begin
                dma_select_n <= 1'b0;
            end else if (good_done) begin
                if ((group_cnt == group_last) || last_byte) begin
                    dma_select_n <= 1'b1;
                    group_cnt <= '0;
                end else begin
                    group_cnt <= group_cnt + 2'h1;
                end
            end
        end
    end

endmodule : sdt_core

// ---- sim/sdt_properties.sv ----
// Purpose: port timing properties of the serial DMA transfer control
// Assumes: control and SRAM side share core_clk
// Notes: attached to sdt_core by the bind at the foot
`timescale 1ns/1ps
module sdt_props
    import sdt_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic deep_sleep,
    input wire logic transfer_start,
    input wire logic master_mode,
    input wire logic [1:0] direction_select,
    input wire logic tx_pointer_step,
    input wire logic rx_pointer_step,
    input wire logic [1:0] select_pulse_control,
    input wire logic [9:0] byte_count_load,
    input wire logic [11:0] tx_addr_load,
    input wire logic [11:0] rx_addr_load,
    input wire logic transfer_active_bit,
    input wire logic [11:0] transmit_source_pointer,
    input wire logic [11:0] receive_dest_pointer,
    input wire logic [9:0] transfer_byte_count,
    input wire logic [11:0] sram_addr,
    input wire logic sram_rd,
    input wire logic sram_wr,
    input wire logic dma_select_oe_n
);
    import sdt_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire go = transfer_start && !transfer_active_bit && !deep_sleep;
    ////////////////////////////////////////////////////////////////
    a_start_active: assert property (go |=> transfer_active_bit)
        else $error("start did not raise active");
    a_start_load: assert property (go |=> transfer_byte_count == $past(byte_count_load)
        && transmit_source_pointer == $past(tx_addr_load)
        && receive_dest_pointer == $past(rx_addr_load)) else $error("start load wrong");
    a_deep_clears: assert property (deep_sleep |=> !transfer_active_bit)
        else $error("deep sleep left active");
    a_idle_no_sram: assert property (!transfer_active_bit |=> !sram_rd && !sram_wr)
        else $error("sram access while inactive");
    a_idle_frozen: assert property (!transfer_active_bit ##1 !transfer_active_bit |->
        $stable(transfer_byte_count) && $stable(transmit_source_pointer)
        && $stable(receive_dest_pointer)) else $error("state moved while inactive");
    a_rd_at_ptr: assert property (sram_rd |-> sram_addr == transmit_source_pointer)
        else $error("read not at source pointer");
    a_tx_fixed: assert property (transfer_active_bit && !tx_pointer_step ##1
        transfer_active_bit |-> $stable(transmit_source_pointer)) else $error("tx pointer moved");
    a_rx_fixed: assert property (transfer_active_bit && !rx_pointer_step ##1
        transfer_active_bit |-> $stable(receive_dest_pointer)) else $error("rx pointer moved");
    a_count_dec: assert property (transfer_active_bit ##1 transfer_active_bit
        && $changed(transfer_byte_count) |-> transfer_byte_count == $past(transfer_byte_count)
        - 10'h001) else $error("count step wrong");
    a_rx_no_read: assert property (transfer_active_bit && direction_select == DIR_RX
        |-> !sram_rd) else $error("read in receive only");
    a_tx_no_write: assert property (transfer_active_bit && direction_select == DIR_TX
        |-> !sram_wr) else $error("write in transmit only");
    a_sel_free: assert property (transfer_active_bit && select_pulse_control == SEL_NONE
        ##1 transfer_active_bit |-> dma_select_oe_n) else $error("select driven when free");
    c_master: cover property (go && master_mode);
    c_slave: cover property (go && !master_mode);
    c_abort: cover property ($fell(transfer_active_bit) && transfer_byte_count != 10'h000);
endmodule : sdt_props

bind sdt_core sdt_props sdt_props_inst (.core_clk, .resetn, .deep_sleep, .transfer_start,
    .master_mode, .direction_select, .tx_pointer_step, .rx_pointer_step, .select_pulse_control,
    .byte_count_load, .tx_addr_load, .rx_addr_load, .transfer_active_bit,
    .transmit_source_pointer, .receive_dest_pointer, .transfer_byte_count, .sram_addr,
    .sram_rd, .sram_wr, .dma_select_oe_n);

// ---- sim/sdt_peer.sv ----
// Purpose: serial peer on the far side of the link
// Assumes: bench gates link_clk into frames
// Notes: echoes the line when the block is master
`timescale 1ns/1ps
module sdt_peer (
    input wire logic link_clk,
    input wire logic resetn,
    input wire logic loop,
    input wire logic port_two_select_n,
    input wire logic serial_out_two,
    input wire logic [7:0] send_byte,
    output logic serial_in_two,
    output logic [7:0] heard
);
    logic [2:0] bit_idx;
    // deselected line shows the inverse of its last bit
    assign serial_in_two = loop ? serial_out_two :
        port_two_select_n ? ~send_byte[0] : send_byte[3'h7 - bit_idx];
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            bit_idx <= 3'h0;
            heard <= 8'h00;
        end else if (!loop && !port_two_select_n) begin
            bit_idx <= bit_idx + 3'h1;
            heard <= {heard[6:0], serial_out_two};
        end
    end
endmodule : sdt_peer

// ---- sim/tb.sv ----
// Purpose: self-checking bench of the serial DMA transfer control
// Assumes: SRAM answers combinationally from the held address
// Notes: master runs loop back, slave runs use framed link clocks
`timescale 1ns/1ps
module tb;
    import sdt_pkg::*;
    logic core_clk = 0, link_clk = 0, resetn = 0, sleep_mode = 0, deep_sleep = 0;
    logic transfer_start = 0, transfer_stop = 0, flag_clear = 0, master_mode = 1;
    logic tx_pointer_step = 1, rx_pointer_step = 1, delay_interrupt_select = 0;
    logic [1:0] direction_select = 0, select_pulse_control = 0, clock_rate_select = 0;
    logic [3:0] delay_cycle_field = 0, watermark_level = 0;
    logic [9:0] byte_count_load = 0, transfer_byte_count;
    logic [11:0] tx_addr_load = 12'h100, rx_addr_load = 12'h200, sram_addr;
    logic [11:0] transmit_source_pointer, receive_dest_pointer;
    logic port_two_select_n = 1, slave_run = 0, sel_q = 1, link_run;
    logic transfer_active_bit, serial_port_two_flag, sram_rd, sram_wr, serial_out_two;
    logic serial_in_two, dma_select_n, dma_select_oe_n, master_clk_run;
    logic [7:0] send_byte = 8'h00, sram_wdata, heard, sram_rdata;
    logic [7:0] mem [4096];
    logic [7:0] snap [4096];
    logic [1:0] r_dir [4] = '{DIR_FULL, DIR_FULL, DIR_RX, DIR_TX};
    logic [1:0] r_sel [4] = '{SEL_FOUR, SEL_TWO, SEL_ONE, SEL_NONE};
    logic r_txs [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic r_rxs [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    int r_cnt [4] = '{3, 3, 2, 1};
    int r_rise [4] = '{1, 2, 3, 0};
    int err_total = 0, num_checks = 0, cyc = 0, sel_rises = 0, n = 0;
    sdt_core sdt_core_inst (.*);
    sdt_peer sdt_peer_inst (.loop(master_mode), .*);
    assign sram_rdata = mem[sram_addr];
    assign link_run = !resetn || (master_mode ? master_clk_run : slave_run);
    initial forever #10 core_clk = ~core_clk;
    initial begin
        #7;
        forever begin
            #62.5;
            if (link_run || link_clk) link_clk = ~link_clk;
        end
    end
    always @(posedge core_clk) begin
        if (sram_wr) mem[sram_addr] <= sram_wdata;
        sel_q <= dma_select_n;
        if (dma_select_n && !sel_q) sel_rises++;
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////
    task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task do_reset;
        resetn = 0;
        repeat (20) @(negedge core_clk);
        resetn = 1;
        @(negedge core_clk);
    endtask : do_reset
    task start_xfer(input logic [9:0] cnt);
        @(negedge core_clk) byte_count_load = cnt;
        transfer_start = 1;
        @(negedge core_clk) transfer_start = 0;
    endtask : start_xfer
    task wait_idle;
        for (int i = 0; i < 20000 && transfer_active_bit !== 1'b0; i++) @(negedge core_clk);
    endtask : wait_idle
    task frame(input logic [7:0] b);
        send_byte = b;
        slave_run = 1;
        repeat (5) @(posedge link_clk);
        @(negedge link_clk) port_two_select_n = 0;
        repeat (8) @(posedge link_clk);
        @(negedge link_clk) port_two_select_n = 1;
        slave_run = 0;
        repeat (20) @(negedge core_clk);
    endtask : frame
    task test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + 5);
        do_reset();
        for (int r = 0; r < 4; r++) begin
            snap = mem;
            n = r_cnt[r] + 1;
            @(negedge core_clk) direction_select = r_dir[r];
            tx_pointer_step = r_txs[r];
            rx_pointer_step = r_rxs[r];
            select_pulse_control = r_sel[r];
            for (int i = 0; i < n; i++) if (r_dir[r] != DIR_TX)
                snap[rx_addr_load + (r_rxs[r] ? i : 0)] = (r_dir[r] == DIR_RX) ? TX_FILL
                    : snap[tx_addr_load + (r_txs[r] ? i : 0)];
            sel_rises = 0;
            start_xfer(10'(r_cnt[r]));
            wait_idle();
            check("count", transfer_byte_count, 12'h000);
            check("select groups", 12'(sel_rises), 12'(r_rise[r]));
            if (r_dir[r] != DIR_RX) check("tx ptr", transmit_source_pointer,
                tx_addr_load + 12'(r_txs[r] ? n : 0));
            if (r_dir[r] != DIR_TX) check("rx ptr", receive_dest_pointer,
                rx_addr_load + 12'(r_rxs[r] ? n : 0));
            for (int i = 0; i < 6; i++) check("sram", mem[rx_addr_load + i],
                snap[rx_addr_load + i]);
        end
        direction_select = DIR_FULL;
        sleep_mode = 1;
        start_xfer(10'h001);
        repeat (300) @(negedge core_clk);
        check("sleep count", transfer_byte_count, 12'h001);
        sleep_mode = 0;
        wait_idle();
        check("idle count", transfer_byte_count, 12'h000);
        start_xfer(10'h005);
        for (int i = 0; i < 500 && master_clk_run !== 1'b1; i++) @(negedge core_clk);
        repeat (40) @(negedge core_clk);
        transfer_stop = 1;
        @(negedge core_clk) transfer_stop = 0;
        repeat (300) @(negedge core_clk);
        check("stop active", transfer_active_bit, 12'h000);
        check("stop count", transfer_byte_count, 12'h005);
        start_xfer(10'h003);
        repeat (60) @(negedge core_clk);
        deep_sleep = 1;
        repeat (3) @(negedge core_clk);
        check("deep active", transfer_active_bit, 12'h000);
        deep_sleep = 0;
        do_reset();
        master_mode = 0;
        delay_interrupt_select = 1;
        delay_cycle_field = 4'h3;
        start_xfer(10'h001);
        repeat (60) @(negedge core_clk);
        check("armed count", transfer_byte_count, 12'h001);
        frame(8'h3C);
        check("slave tx 0", heard, mem[tx_addr_load]);
        repeat (40) @(negedge core_clk);
        check("timeout flag", serial_port_two_flag, 12'h001);
        flag_clear = 1;
        @(negedge core_clk) flag_clear = 0;
        frame(8'hA5);
        wait_idle();
        check("slave tx 1", heard, mem[tx_addr_load + 1]);
        check("slave rx 0", mem[rx_addr_load], 12'h03C);
        check("slave rx 1", mem[rx_addr_load + 1], 12'h0A5);
        check("end flag", serial_port_two_flag, 12'h001);
        check("end active", transfer_active_bit, 12'h000);
        test_done();
    end
endmodule : tb
